// [src/fac_top.sv]
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - A four-bit flash converter usable at three-bit or four-bit resolution.
// - The input comes from one of four analog channels through a mux.
// - Channel code 00..11 picks channel 0..3 and resets to 00.
// - Channel field is bits 4:3 (three-bit reg) and bits 5:4 (four-bit reg).
// - Three-bit results land in bits 2:0 of the three-bit register.
// - Four-bit results land in bits 3:0 of the four-bit register.
// - Speed field is bits 6:5 (three-bit reg) and bits 7:6 (four-bit reg).
// - Speed 00 stops the converter at reset; 01/10/11 divide clock by 2/3/4.
// - The selected input is sampled once per eight conversion-clock ticks.
// - The result is the last sample taken, or a value software wrote since; with speed 00 it does not follow the channel.
module fac_top (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [fac_pkg::FAC_ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	// axi4-lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [fac_pkg::FAC_DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	// axi4-lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// axi4-lite read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [fac_pkg::FAC_ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	// axi4-lite read data
	output logic rvalid,
	input wire logic rready,
	output logic [fac_pkg::FAC_DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	// comparator ladder and input mux
	input wire logic [3:0] flash_code,
	output logic [1:0] chan_sel,
	output logic sample_strobe,
	output logic conv_active,
	output logic mode_4b
);
	import fac_pkg::*;

	// write channel holding
	logic aw_full_q, aw_full_d;
	logic [FAC_ADDR_W-1:0] aw_addr_q, aw_addr_d;
	logic w_full_q, w_full_d;
	logic [FAC_REG_W-1:0] w_data_q, w_data_d;
	logic w_lane_q, w_lane_d;
	logic bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d;
	// read channel
	logic rvalid_q, rvalid_d;
	logic [FAC_DATA_W-1:0] rdata_q, rdata_d;
	logic [1:0] rresp_q, rresp_d;
	// three-bit mode register
	logic [1:0] spd3_q, spd3_d;
	logic [1:0] ch3_q, ch3_d;
	logic [FAC_3B_RES_W-1:0] res3_q, res3_d;
	// four-bit mode register
	logic [1:0] spd4_q, spd4_d;
	logic [1:0] ch4_q, ch4_d;
	logic [FAC_4B_RES_W-1:0] res4_q, res4_d;
	// converter sequencing
	logic mode4_q, mode4_d;
	logic [2:0] tcnt_q, tcnt_d;
	logic strobe_q, strobe_d;
	logic restart_q, restart_d;
	// combinational helpers
	logic do_write, hit3, hit4;
	logic [1:0] act_spd, act_ch;
	logic conv_tick, sample_now;
	logic [FAC_REG_W-1:0] view3, view4;

	// register views as software reads them
	always_comb begin
		view3 = '0;
		view3[FAC_3B_RSVD_BIT] = FAC_3B_RSVD_VAL;
		view3[FAC_3B_SPD_LSB +: 2] = spd3_q;
		view3[FAC_3B_CH_LSB +: 2] = ch3_q;
		view3[FAC_3B_RES_LSB +: FAC_3B_RES_W] = res3_q;
		view4 = '0;
		view4[FAC_4B_SPD_LSB +: 2] = spd4_q;
		view4[FAC_4B_CH_LSB +: 2] = ch4_q;
		view4[FAC_4B_RES_LSB +: FAC_4B_RES_W] = res4_q;
	end

	// the register written last decides the resolution in use
	assign act_spd = mode4_q ? spd4_q : spd3_q;
	assign act_ch = mode4_q ? ch4_q : ch3_q;

	assign do_write = aw_full_q && w_full_q && !bvalid_q;
	assign hit3 = aw_addr_q == FAC_ADDR_3B;
	assign hit4 = aw_addr_q == FAC_ADDR_4B;

	fac_div u_div (
		.aclk(aclk),
		.aresetn(aresetn),
		.speed(act_spd),
		.restart(restart_q),
		.tick(conv_tick)
	);

	// sample on the eighth conversion tick of a window; never in the
	// restart cycle, where a stale tick would latch the old channel
	assign sample_now = conv_tick && tcnt_q == FAC_TICK_TC
		&& !restart_q;

	// axi write path: address and data taken in either order
	always_comb begin
		aw_full_d = aw_full_q;
		aw_addr_d = aw_addr_q;
		w_full_d = w_full_q;
		w_data_d = w_data_q;
		w_lane_d = w_lane_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		if (awvalid && awready) begin
			aw_full_d = 1'b1;
			aw_addr_d = awaddr;
		end
		if (wvalid && wready) begin
			w_full_d = 1'b1;
			w_data_d = wdata[FAC_REG_W-1:0];
			w_lane_d = wstrb[0];
		end
		if (do_write) begin
			aw_full_d = 1'b0;
			w_full_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = (hit3 || hit4) ? FAC_RESP_OKAY : FAC_RESP_SLVERR;
		end else if (bvalid_q && bready) begin
			bvalid_d = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			aw_addr_q <= '0;
			w_full_q <= 1'b0;
			w_data_q <= '0;
			w_lane_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= FAC_RESP_OKAY;
		end else begin
			aw_full_q <= aw_full_d;
			aw_addr_q <= aw_addr_d;
			w_full_q <= w_full_d;
			w_data_q <= w_data_d;
			w_lane_q <= w_lane_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
		end
	end

	assign awready = !aw_full_q;
	assign wready = !w_full_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;

	// axi read path: one read at a time, answered a cycle after acceptance
	always_comb begin
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (arvalid && arready) begin
			rvalid_d = 1'b1;
			rdata_d = '0;
			rresp_d = FAC_RESP_OKAY;
			if (araddr == FAC_ADDR_3B) begin
				rdata_d[FAC_REG_W-1:0] = view3;
			end else if (araddr == FAC_ADDR_4B) begin
				rdata_d[FAC_REG_W-1:0] = view4;
			end else begin
				rresp_d = FAC_RESP_SLVERR;
			end
		end else if (rvalid_q && rready) begin
			rvalid_d = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= FAC_RESP_OKAY;
		end else begin
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	assign arready = !rvalid_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;

	// control fields and results
	always_comb begin
		spd3_d = spd3_q;
		ch3_d = ch3_q;
		res3_d = res3_q;
		spd4_d = spd4_q;
		ch4_d = ch4_q;
		res4_d = res4_q;
		mode4_d = mode4_q;
		restart_d = 1'b0;
		// writes without the low byte lane leave the register alone
		if (do_write && w_lane_q && hit3) begin
			spd3_d = w_data_q[FAC_3B_SPD_LSB +: 2];
			ch3_d = w_data_q[FAC_3B_CH_LSB +: 2];
			res3_d = w_data_q[FAC_3B_RES_LSB +: FAC_3B_RES_W];
			mode4_d = 1'b0;
			restart_d = 1'b1;
		end
		if (do_write && w_lane_q && hit4) begin
			spd4_d = w_data_q[FAC_4B_SPD_LSB +: 2];
			ch4_d = w_data_q[FAC_4B_CH_LSB +: 2];
			res4_d = w_data_q[FAC_4B_RES_LSB +: FAC_4B_RES_W];
			mode4_d = 1'b1;
			restart_d = 1'b1;
		end
		// a fresh conversion wins over a software write in the same cycle
		if (sample_now && !mode4_q) begin
			res3_d = flash_code[3 -: FAC_3B_RES_W];
		end
		if (sample_now && mode4_q) begin
			res4_d = flash_code;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			spd3_q <= FAC_SPD_RST;
			ch3_q <= FAC_CH_RST;
			res3_q <= FAC_RES_RST[FAC_3B_RES_W-1:0];
			spd4_q <= FAC_SPD_RST;
			ch4_q <= FAC_CH_RST;
			res4_q <= FAC_RES_RST;
			mode4_q <= 1'b0;
			restart_q <= 1'b0;
		end else begin
			spd3_q <= spd3_d;
			ch3_q <= ch3_d;
			res3_q <= res3_d;
			spd4_q <= spd4_d;
			ch4_q <= ch4_d;
			res4_q <= res4_d;
			mode4_q <= mode4_d;
			restart_q <= restart_d;
		end
	end

	// sampling window: restarted on any control write so that the
	// next result comes wholly from the newly selected channel
	always_comb begin
		tcnt_d = tcnt_q;
		strobe_d = 1'b0;
		if (act_spd == FAC_SPD_OFF || restart_q) begin
			tcnt_d = 3'h0;
		end else if (conv_tick) begin
			tcnt_d = tcnt_q + 3'h1;
			strobe_d = sample_now;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tcnt_q <= 3'h0;
			strobe_q <= 1'b0;
		end else begin
			tcnt_q <= tcnt_d;
			strobe_q <= strobe_d;
		end
	end

	// mux select follows the active register's channel field
	assign chan_sel = act_ch;
	assign sample_strobe = strobe_q;
	assign conv_active = act_spd != FAC_SPD_OFF;
	assign mode_4b = mode4_q;

endmodule // fac_top

`default_nettype wire

// [src/fac_pkg.sv]
package fac_pkg;

	// bus geometry
	localparam int unsigned FAC_ADDR_W = 4;
	localparam int unsigned FAC_DATA_W = 32;
	localparam int unsigned FAC_REG_W = 8;

	// register indices; byte address is four times the index
	localparam logic [1:0] FAC_IDX_3B = 2'h0;
	localparam logic [1:0] FAC_IDX_4B = 2'h1;
	localparam logic [FAC_ADDR_W-1:0] FAC_ADDR_3B = {FAC_IDX_3B, 2'h0};
	localparam logic [FAC_ADDR_W-1:0] FAC_ADDR_4B = {FAC_IDX_4B, 2'h0};

	// three-bit mode register fields
	localparam int unsigned FAC_3B_RSVD_BIT = 7;
	localparam int unsigned FAC_3B_SPD_LSB = 5;
	localparam int unsigned FAC_3B_CH_LSB = 3;
	localparam int unsigned FAC_3B_RES_LSB = 0;
	localparam int unsigned FAC_3B_RES_W = 3;
	localparam logic FAC_3B_RSVD_VAL = 1'b1;

	// four-bit mode register fields
	localparam int unsigned FAC_4B_SPD_LSB = 6;
	localparam int unsigned FAC_4B_CH_LSB = 4;
	localparam int unsigned FAC_4B_RES_LSB = 0;
	localparam int unsigned FAC_4B_RES_W = 4;

	// reset values
	localparam logic [1:0] FAC_SPD_RST = 2'h0;
	localparam logic [1:0] FAC_CH_RST = 2'h0;
	localparam logic [3:0] FAC_RES_RST = 4'h0;

	// speed codes
	localparam logic [1:0] FAC_SPD_OFF = 2'h0;
	localparam logic [1:0] FAC_SPD_DIV2 = 2'h1;
	localparam logic [1:0] FAC_SPD_DIV3 = 2'h2;
	localparam logic [1:0] FAC_SPD_DIV4 = 2'h3;

	// divide ratios, stored as terminal count (ratio - 1)
	localparam logic [1:0] FAC_DIV2_TC = 2'h1;
	localparam logic [1:0] FAC_DIV3_TC = 2'h2;
	localparam logic [1:0] FAC_DIV4_TC = 2'h3;

	// conversion-clock ticks per sample of the analog input
	localparam int unsigned FAC_TICKS_PER_SAMPLE = 8;
	localparam logic [2:0] FAC_TICK_TC = 3'(FAC_TICKS_PER_SAMPLE - 1);

	// axi responses
	localparam logic [1:0] FAC_RESP_OKAY = 2'h0;
	localparam logic [1:0] FAC_RESP_SLVERR = 2'h2;

endpackage

// [src/fac_div.sv]
`timescale 1ns/1ps
`default_nettype none

module fac_div (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// control
	input wire logic [1:0] speed,
	input wire logic restart,
	// one-cycle conversion-clock enable
	output logic tick
);
	import fac_pkg::*;

	logic [1:0] cnt_q, cnt_d;
	logic [1:0] tc;
	logic tick_q, tick_d;

	always_comb begin
		unique case (speed)
			FAC_SPD_DIV2: tc = FAC_DIV2_TC;
			FAC_SPD_DIV3: tc = FAC_DIV3_TC;
			FAC_SPD_DIV4: tc = FAC_DIV4_TC;
			default: tc = FAC_DIV2_TC;
		endcase
		cnt_d = cnt_q;
		tick_d = 1'b0;
		// stopped converter: counter parked so a start is always aligned
		if (speed == FAC_SPD_OFF || restart) begin
			cnt_d = 2'h0;
		end else if (cnt_q >= tc) begin
			cnt_d = 2'h0;
			tick_d = 1'b1;
		end else begin
			cnt_d = cnt_q + 2'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= 2'h0;
			tick_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;

endmodule // fac_div

`default_nettype wire

// [tb/fac_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module fac_monitor
	import fac_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [fac_pkg::FAC_ADDR_W-1:0] araddr,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [fac_pkg::FAC_DATA_W-1:0] rdata,
	input wire logic [1:0] rresp,
	// converter
	input wire logic sample_strobe,
	input wire logic conv_active
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_write_answer: assert property (awvalid && awready && wvalid && wready
		|-> ##2 bvalid) else $error("write response late");
	a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");
	a_read_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read data late");
	a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped");
	a_ar_blocked: assert property (rvalid |-> !arready)
		else $error("read taken while busy");
	a_bad_read: assert property (arvalid && arready && araddr != FAC_ADDR_3B
		&& araddr != FAC_ADDR_4B |=> rresp == FAC_RESP_SLVERR && rdata == 32'h0)
		else $error("unmapped read accepted");
	a_upper_zero: assert property (rvalid |-> rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_strobe_gap: assert property (
		sample_strobe |=> !sample_strobe [*8]) else $error("samples too close");
	a_idle_quiet: assert property (
		!conv_active && !$past(conv_active) |-> !sample_strobe)
		else $error("sample while stopped");
endmodule // fac_monitor
bind fac_top fac_monitor mon_u (.aclk, .aresetn, .awvalid, .awready, .wvalid,
	.wready, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
	.rready, .rdata, .rresp, .sample_strobe, .conv_active);
`default_nettype wire

// [tb/fac_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module fac_top_tb;
	import fac_pkg::*;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, sample_strobe, conv_active, mode_4b;
	logic [3:0] awaddr, araddr, wstrb, flash_code;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp, chan_sel;
	int n_mismatch, compares, n;
	fac_top dut_u (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0),
		.wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
		.arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp,
		.flash_code, .chan_sel, .sample_strobe, .conv_active, .mode_4b);
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	task automatic final_report;
		if (n_mismatch == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic hang(input string nm);
		n_mismatch++;
		$display("Error %s expected done seen timeout", nm);
		final_report();
	endtask
	// handshakes are sampled at the falling edge: nothing moves between
	// it and the rising edge, so this is what the design sees there
	task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
		bit dn, aw_t, w_t, b_t;
		logic [1:0] b_seen;
		@(posedge aclk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= {24'h0, d};
		bready <= 1'b1;
		dn = 1'b0;
		for (int i = 0; i < 50 && !dn; i++) begin
			@(negedge aclk);
			aw_t = awvalid && awready;
			w_t = wvalid && wready;
			b_t = bvalid;
			b_seen = bresp;
			@(posedge aclk);
			if (aw_t) awvalid <= 1'b0;
			if (w_t) wvalid <= 1'b0;
			if (b_t) begin
				dn = 1'b1;
				bready <= 1'b0;
				chk("bresp", {30'h0, er}, {30'h0, b_seen});
			end
		end
		if (!dn) hang("write");
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [1:0] er);
		bit dn, ar_t, r_t;
		logic [31:0] r_data;
		logic [1:0] r_resp;
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		dn = 1'b0;
		for (int i = 0; i < 50 && !dn; i++) begin
			@(negedge aclk);
			ar_t = arvalid && arready;
			r_t = rvalid;
			r_data = rdata;
			r_resp = rresp;
			@(posedge aclk);
			if (ar_t) arvalid <= 1'b0;
			if (r_t) begin
				dn = 1'b1;
				rready <= 1'b0;
				chk("rdata", {24'h0, e}, r_data);
				chk("rresp", {30'h0, er}, {30'h0, r_resp});
			end
		end
		if (!dn) hang("read");
	endtask
	// cycles from the previous strobe (or call) to the next one land in n
	task automatic wt;
		bit st;
		for (n = 1; n <= 100; n++) begin
			@(negedge aclk);
			st = sample_strobe;
			@(posedge aclk);
			if (st) return;
		end
		hang("strobe");
	endtask
	initial begin
		aresetn = 1'b0;
		awvalid = 1'b0;
		awaddr = 4'h0;
		wvalid = 1'b0;
		wdata = 32'h0;
		wstrb = 4'hf;
		bready = 1'b0;
		arvalid = 1'b0;
		araddr = 4'h0;
		rready = 1'b0;
		flash_code = 4'h0;
		n_mismatch = 0;
		compares = 0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rd(FAC_ADDR_3B, 8'h80, FAC_RESP_OKAY);
		rd(FAC_ADDR_4B, 8'h00, FAC_RESP_OKAY);
		chk("conv_active", 0, {31'h0, conv_active});
		rd(4'h8, 8'h00, FAC_RESP_SLVERR);
		wr(4'hc, 8'hff, FAC_RESP_SLVERR);
		rd(FAC_ADDR_4B, 8'h00, FAC_RESP_OKAY);
		// shared pins are set up for analog input outside the block
		for (int c = 0; c < 4; c++) begin
			wr(FAC_ADDR_4B, {FAC_SPD_OFF, 2'(c), 4'h0}, FAC_RESP_OKAY);
			chk("chan_sel", c, {30'h0, chan_sel});
		end
		// every divide ratio; code changes between samples must show
		// fields written before any result is trusted
		for (int s = 1; s < 4; s++) begin
			flash_code <= 4'(s);
			wr(FAC_ADDR_4B, {2'(s), 2'h2, 4'h0}, FAC_RESP_OKAY);
			chk("mode_4b", 1, {31'h0, mode_4b});
			chk("conv_active", 1, {31'h0, conv_active});
			wt();
			flash_code <= 4'(s + 8);
			wt();
			chk("period", 8 * (s + 1), n);
			rd(FAC_ADDR_4B, {2'(s), 2'h2, 4'(s + 8)}, FAC_RESP_OKAY);
		end
		flash_code <= 4'hb;
		wr(FAC_ADDR_3B, {1'b0, FAC_SPD_DIV4, 2'h1, 3'h0}, FAC_RESP_OKAY);
		chk("chan_sel", 1, {30'h0, chan_sel});
		chk("mode_4b", 0, {31'h0, mode_4b});
		wt();
		rd(FAC_ADDR_3B, {1'b1, FAC_SPD_DIV4, 2'h1, 3'h5}, FAC_RESP_OKAY);
		// stopped: a software-written result must stand
		wr(FAC_ADDR_3B, 8'h0a, FAC_RESP_OKAY);
		flash_code <= 4'h4;
		repeat (40) @(posedge aclk);
		rd(FAC_ADDR_3B, 8'h8a, FAC_RESP_OKAY);
		chk("conv_active", 0, {31'h0, conv_active});
		// a write without the low byte lane is answered and ignored
		wstrb <= 4'he;
		wr(FAC_ADDR_3B, 8'h7f, FAC_RESP_OKAY);
		wstrb <= 4'hf;
		rd(FAC_ADDR_3B, 8'h8a, FAC_RESP_OKAY);
		final_report();
	end
endmodule // fac_top_tb
`default_nettype wire
